/* core/rxdiag_pkg.sv */
// Package for the receive FIFO diagnostic and PHY option register block
`default_nettype none
// Contract
// R01: Live receive head is 13 bits [12:0], 64-bit word units, resets to zero.
// R02: Head is an offset from the start of packet buffer memory.
// R03: Head register also answers at a compatibility alias address.
// R04: Live receive tail is 13 bits, 64-bit word units, resets to zero.
// R05: Tail has an alias address and is a packet-buffer-relative offset.
// R06: Saved head register, 13 bits, reset zero, copy for later restore.
// R07: Saved tail register, 13 bits, reset zero, copy for later restore.
// R08: Pointer bits 31:13 read zero; software writes zeros there.
// R09: Software writes pointer registers only for diagnostics, not in normal use.
// R10: Option bit 1 forces slowest link in every state, overriding bit 2.
// R11: Option bit 2 forces slowest link in all but the active state.
// R12: Option bit 3 blocks gigabit link in all but the active state.
// R13: Option bit 6 blocks gigabit link in every power state.
// R14: Writing option bit 5 forces link auto-negotiation to restart.
// R15: Option bit 7 stops automatic flash update on eeprom-read writes.
// R16: Bits 8 and 9 drive pause and asymmetric pause advertisement, reset one.
// R17: After reset, option bits 7:0 load from a non-volatile word high byte.
// R18: Software waits 80 ns after speed-bit changes before forcing renegotiation.
// R19: Live pointer reads return the receive FIFO logic's current pointers.
package rxdiag_pkg;
  localparam logic [19:0] ADDR_PHY_OPT = 20'h00f10;
  localparam logic [19:0] ADDR_RX_HEAD = 20'h02410;
  localparam logic [19:0] ADDR_RX_TAIL = 20'h02418;
  localparam logic [19:0] ADDR_RX_HEAD_SAVED = 20'h02420;
  localparam logic [19:0] ADDR_RX_TAIL_SAVED = 20'h02428;
  localparam logic [19:0] ADDR_RX_HEAD_ALIAS = 20'h08000;
  localparam logic [19:0] ADDR_RX_TAIL_ALIAS = 20'h08008;
  localparam int PTR_W = 13;
  localparam int OPT_W = 10;
  localparam logic [PTR_W-1:0] PTR_RST = 13'h0000;
  localparam logic [OPT_W-1:0] OPT_RST = 10'h30d;
  localparam int BIT_SLOW_ALL = 1;
  localparam int BIT_SLOW_LP = 2;
  localparam int BIT_GIG_BLOCK_LP = 3;
  localparam int BIT_LINE_DRV = 4;
  localparam int BIT_RENEG = 5;
  localparam int BIT_GIG_DIS = 6;
  localparam int BIT_AUTO_UPD_DIS = 7;
  localparam int BIT_PAUSE = 8;
  localparam int BIT_ASYM_PAUSE = 9;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RENEG_WAIT_NS = 80;
  localparam int RENEG_WAIT_CYC =
    (RENEG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef struct packed {
    logic slow_link;
    logic gig_disable;
    logic pause_adv;
    logic asym_pause_adv;
    logic line_driver_class_select;
    logic flash_auto_update_dis;
  } rxdiag_phy_ctl_t;

  typedef struct packed {
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] tail;
  } rxdiag_ptrs_t;
endpackage : rxdiag_pkg
`default_nettype wire

/* core/rxdiag_regs.sv */
// AHB-Lite register bank: PHY option bits and receive FIFO pointer diagnostics
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module rxdiag_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [19:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic nvm_valid,
  input wire logic [7:0] nvm_opt_byte,
  input wire logic active_power_state,
  input wire rxdiag_pkg::rxdiag_ptrs_t rx_ptrs_live,
  output rxdiag_pkg::rxdiag_ptrs_t rx_ptrs_load,
  output logic rx_head_load,
  output logic rx_tail_load,
  output rxdiag_pkg::rxdiag_phy_ctl_t phy_ctl,
  output logic phy_reneg
);
  import rxdiag_pkg::*;

  // Bus state
  logic wr_pend_q, wr_pend_d;
  logic [19:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  // Register state
  logic [OPT_W-1:0] opt_q, opt_d;
  logic [PTR_W-1:0] head_sv_q, head_sv_d;
  logic [PTR_W-1:0] tail_sv_q, tail_sv_d;
  logic nvm_done_q, nvm_done_d;
  // Outputs
  rxdiag_ptrs_t load_q, load_d;
  logic hload_q, hload_d, tload_q, tload_d;
  rxdiag_phy_ctl_t ctl_q, ctl_d;
  logic reneg_q, reneg_d;

  logic acc;
  logic [PTR_W-1:0] wptr;

  always_comb begin
    acc = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wptr = hwdata[PTR_W-1:0]; // R08
    wr_pend_d = acc && hwrite;
    addr_d = acc ? haddr : addr_q;
    rdata_d = 32'h0000_0000; // R08
    if (acc && !hwrite) begin
      unique case ({haddr[19:2], 2'b00})
        ADDR_PHY_OPT: rdata_d = {22'h0, opt_q};
        ADDR_RX_HEAD, ADDR_RX_HEAD_ALIAS:
          rdata_d = {19'h0, rx_ptrs_live.head}; // R01 R02 R03 R19
        ADDR_RX_TAIL, ADDR_RX_TAIL_ALIAS:
          rdata_d = {19'h0, rx_ptrs_live.tail}; // R04 R05 R19
        ADDR_RX_HEAD_SAVED: rdata_d = {19'h0, head_sv_q}; // R06
        ADDR_RX_TAIL_SAVED: rdata_d = {19'h0, tail_sv_q}; // R07
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    opt_d = opt_q;
    head_sv_d = head_sv_q;
    tail_sv_d = tail_sv_q;
    nvm_done_d = nvm_done_q;
    load_d = load_q;
    hload_d = 1'b0;
    tload_d = 1'b0;
    reneg_d = 1'b0;
    // Low byte taken once from non-volatile memory after reset
    if (!nvm_done_q && nvm_valid) begin
      opt_d[7:0] = nvm_opt_byte; // R17
      nvm_done_d = 1'b1;
    end
    if (wr_pend_q) begin
      // Live pointer writes are diagnostic overrides of the FIFO logic
      unique case ({addr_q[19:2], 2'b00})
        ADDR_PHY_OPT: begin
          opt_d = hwdata[OPT_W-1:0];
          opt_d[BIT_RENEG] = 1'b0; // Self-clearing strobe
          reneg_d = hwdata[BIT_RENEG]; // R14
        end
        ADDR_RX_HEAD, ADDR_RX_HEAD_ALIAS: begin
          load_d.head = wptr; // R03 R09
          hload_d = 1'b1;
        end
        ADDR_RX_TAIL, ADDR_RX_TAIL_ALIAS: begin
          load_d.tail = wptr; // R05 R09
          tload_d = 1'b1;
        end
        ADDR_RX_HEAD_SAVED: head_sv_d = wptr; // R06
        ADDR_RX_TAIL_SAVED: tail_sv_d = wptr; // R07
        default: ;
      endcase
    end
    ctl_d.slow_link = opt_d[BIT_SLOW_ALL] || // R10
      (opt_d[BIT_SLOW_LP] && !active_power_state); // R11
    ctl_d.gig_disable = opt_d[BIT_GIG_DIS] || // R13
      (opt_d[BIT_GIG_BLOCK_LP] && !active_power_state); // R12
    ctl_d.pause_adv = opt_d[BIT_PAUSE]; // R16
    ctl_d.asym_pause_adv = opt_d[BIT_ASYM_PAUSE]; // R16
    ctl_d.line_driver_class_select = opt_d[BIT_LINE_DRV];
    ctl_d.flash_auto_update_dis = opt_d[BIT_AUTO_UPD_DIS]; // R15
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 20'h00000;
      rdata_q <= 32'h0000_0000;
      opt_q <= OPT_RST; // R16
      head_sv_q <= PTR_RST; // R06
      tail_sv_q <= PTR_RST; // R07
      nvm_done_q <= 1'b0;
      load_q <= '0;
      hload_q <= 1'b0;
      tload_q <= 1'b0;
      ctl_q <= '0;
      reneg_q <= 1'b0;
    end else if (clk_en) begin
      wr_pend_q <= wr_pend_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      opt_q <= opt_d;
      head_sv_q <= head_sv_d;
      tail_sv_q <= tail_sv_d;
      nvm_done_q <= nvm_done_d;
      load_q <= load_d;
      hload_q <= hload_d;
      tload_q <= tload_d;
      ctl_q <= ctl_d;
      reneg_q <= reneg_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1; // Zero wait states
  assign hresp = 1'b0;
  assign rx_ptrs_load = load_q;
  assign rx_head_load = hload_q;
  assign rx_tail_load = tload_q;
  assign phy_ctl = ctl_q;
  assign phy_reneg = reneg_q;
endmodule : rxdiag_regs
`default_nettype wire

/* tb/rxdiag_props.sv */
// Port checks for the receive diagnostic register bank
`timescale 1ns/1ns
`default_nettype none
module rxdiag_props import rxdiag_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [19:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire rxdiag_pkg::rxdiag_ptrs_t rx_ptrs_live,
  input wire rxdiag_pkg::rxdiag_ptrs_t rx_ptrs_load,
  input wire logic rx_head_load,
  input wire logic rx_tail_load,
  input wire logic phy_reneg
);
  logic rd;
  logic wr;
  logic wopt;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign wr = hsel && hready && htrans[1] && hwrite;
  assign wopt = wr && haddr == ADDR_PHY_OPT;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  head_read_a: assert property (rd && haddr == ADDR_RX_HEAD
    |=> hrdata == {19'h0, $past(rx_ptrs_live.head)}) else $error("head");
  head_alias_a: assert property (rd && haddr == ADDR_RX_HEAD_ALIAS
    |=> hrdata == {19'h0, $past(rx_ptrs_live.head)}) else $error("halias");
  tail_read_a: assert property (rd && haddr == ADDR_RX_TAIL
    |=> hrdata == {19'h0, $past(rx_ptrs_live.tail)}) else $error("tail");
  tail_alias_a: assert property (rd && haddr == ADDR_RX_TAIL_ALIAS
    |=> hrdata == {19'h0, $past(rx_ptrs_live.tail)}) else $error("talias");
  saved_upper_a: assert property (rd && haddr[19:4] == 16'h0242
    |=> hrdata[31:13] == 19'h0) else $error("upper bits");
  reneg_pulse_a: assert property (wopt ##1 hwdata[5]
    |=> phy_reneg) else $error("no reneg");
  reneg_cause_a: assert property (phy_reneg
    |-> $past(hwdata[5]) && $past(wopt, 2)) else $error("stray reneg");
  head_load_a: assert property (wr && haddr == ADDR_RX_HEAD ##1 1'b1
    |=> rx_head_load && rx_ptrs_load.head == $past(hwdata[12:0]))
    else $error("head load");
  tail_load_a: assert property (wr && haddr == ADDR_RX_TAIL ##1 1'b1
    |=> rx_tail_load && rx_ptrs_load.tail == $past(hwdata[12:0]))
    else $error("tail load");
endmodule : rxdiag_props
bind rxdiag_regs rxdiag_props u_props (.*);
`default_nettype wire

/* tb/rxdiag_regs_tb.sv */
// Self-checking bench for the receive diagnostic register bank
`timescale 1ns/1ns
`default_nettype none
module rxdiag_regs_tb;
  import rxdiag_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic [19:0] haddr = 20'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic nvm_valid = 1'b0;
  logic [7:0] nvm_opt_byte = 8'h42;
  logic active_power_state = 1'b1;
  rxdiag_ptrs_t rx_ptrs_live = {13'h0008, 13'h1fff};
  wire hready;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rx_head_load, rx_tail_load, phy_reneg;
  rxdiag_ptrs_t rx_ptrs_load;
  rxdiag_phy_ctl_t phy_ctl;
  int err_total = 0;
  int compares = 0;
  assign hready = hreadyout;
  rxdiag_regs dut (.*);
  initial begin
    forever #25 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [19:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 80);
    r = hrdata;
    if (n >= 80) begin
      err_total++;
      end_sim();
    end
  endtask : bus
  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic t_opt;
    rd(ADDR_PHY_OPT, 32'h30d);
    chk(phy_ctl, 6'b001100);
    nvm_valid <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(ADDR_PHY_OPT, 32'h342);
    chk(phy_ctl, 6'b111100);
    wr(ADDR_PHY_OPT, 32'h08c);
    repeat (2) @(posedge hclk);
    chk(phy_ctl, 6'b000001);
    active_power_state <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(phy_ctl, 6'b110001);
    // Over 80 ns since the speed bits changed
    wr(ADDR_PHY_OPT, 32'h0bc);
    // Strobe stands one cycle, so look mid-cycle
    @(negedge hclk);
    chk(phy_reneg, 1'b1);
    @(posedge hclk);
    rd(ADDR_PHY_OPT, 32'h09c);
    // Frozen state must ignore the power state change
    clk_en <= 1'b0;
    active_power_state <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(phy_ctl, 6'b110011);
    clk_en <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(phy_ctl, 6'b000011);
  endtask : t_opt
  task automatic t_ptrs;
    rd(ADDR_RX_HEAD_SAVED, 32'h0);
    rd(ADDR_RX_TAIL_SAVED, 32'h0);
    rd(ADDR_RX_HEAD, 32'h8);
    rd(ADDR_RX_HEAD_ALIAS, 32'h8);
    rd(ADDR_RX_TAIL_ALIAS, 32'h1fff);
    rx_ptrs_live <= {13'h1234, 13'h0040};
    rd(ADDR_RX_TAIL, 32'h40);
    // Pointer writes only as a diagnostic step
    wr(ADDR_RX_HEAD, 32'hffff_e008);
    @(negedge hclk);
    chk({rx_head_load, rx_ptrs_load.head}, {1'b1, 13'h0008});
    chk({hreadyout, hresp}, 2'b10);
    @(posedge hclk);
    wr(ADDR_RX_TAIL, 32'h0000_0010);
    @(negedge hclk);
    chk({rx_tail_load, rx_ptrs_load.tail}, {1'b1, 13'h0010});
    @(posedge hclk);
    wr(ADDR_RX_HEAD_SAVED, 32'hffff_ffff);
    rd(ADDR_RX_HEAD_SAVED, 32'h1fff);
    wr(ADDR_RX_TAIL_SAVED, 32'h0123);
    rd(ADDR_RX_TAIL_SAVED, 32'h0123);
    wr(20'h02430, 32'hffff_ffff);
    rd(20'h02430, 32'h0);
  endtask : t_ptrs
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_opt();
    t_ptrs();
    end_sim();
  end
endmodule : rxdiag_regs_tb
`default_nettype wire
